// ==== rtl/uhp_cfg.svh ====
`ifndef UHP_CFG_SVH
`define UHP_CFG_SVH
// bus width of the shared address/data lines
`define UHP_BUS_W        8
// register index field (address bits 3..1), select bits 7..6
`define UHP_IDX_LSB      1
`define UHP_IDX_MSB      3
`define UHP_SEL_LSB      6
`define UHP_SEL_MSB      7
// register indices
`define UHP_IDX_MCTL     3'h4
`define UHP_IDX_MSR      3'h6
`define UHP_IDX_SPR      3'h7
`define UHP_IDX_IER      3'h1
// modem control bits
`define UHP_MC_DTR       0
`define UHP_MC_RTS       1
`define UHP_MC_OSRC      3
`define UHP_MC_LOOP      4
`define UHP_MC_INTMODE   5
`define UHP_MC_RING      6
// interrupt enable: modem status bit
`define UHP_IE_MSI       3
// reset values
`define UHP_RST_BYTE     8'h00
// host strobe timing in clock cycles
`define UHP_T_SETUP      2
`define UHP_T_HOLD       2
// read strobe length: covers two sync stages each way plus the drive
`define UHP_T_RDSTRB     6
`endif

// ==== rtl/uhp_pkg.sv ====
package uhp_pkg;
  // host port transfer kinds
  typedef enum logic [1:0]
  {
    UHP_OP_RD = 2'h1,
    UHP_OP_WR = 2'h2
  } uhp_op_t;
  // host sequencer states, one-hot
  typedef enum logic [5:0]
  {
    UHP_H_IDLE = 6'h01,
    UHP_H_ADDR = 6'h02,
    UHP_H_ALAT = 6'h04,
    UHP_H_STRB = 6'h08,
    UHP_H_DONE = 6'h10,
    UHP_H_GAP  = 6'h20
  } uhp_hst_t;
endpackage : uhp_pkg

// ==== rtl/uhp_if.sv ====
interface uhp_if;
  // shared address/data lines, driven by either party
  logic [7:0] host_bus_o;
  logic       host_bus_oe;
  logic [7:0] dev_bus_o;
  logic       dev_bus_oe;
  logic [7:0] shared_bus;
  // control strobes from host, active low
  logic       cs_n;
  logic       addr_latch_n;
  logic       rd_strobe_n;
  logic       wr_strobe_n;
  // interrupt pin: level and enable of the device driver
  logic       irq_o;
  logic       irq_oe;
  // resolve the wire from the enables
  assign shared_bus = host_bus_oe ? host_bus_o :
                      (dev_bus_oe ? dev_bus_o : 8'hFF);
  modport dev
  (
    input  shared_bus, cs_n, addr_latch_n, rd_strobe_n, wr_strobe_n,
    output dev_bus_o, dev_bus_oe, irq_o, irq_oe
  );
  modport host
  (
    input  shared_bus, irq_o, irq_oe,
    output host_bus_o, host_bus_oe, cs_n, addr_latch_n, rd_strobe_n,
           wr_strobe_n
  );
endinterface : uhp_if

// ==== rtl/uhp_host.sv ====
`include "uhp_cfg.svh"
module uhp_host
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  // command port
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  output logic             o_done,
  output logic             o_busy,
  // pins
  uhp_if.host              bus
);
  import uhp_pkg::*;

  uhp_hst_t   st_q, st_d;          // sequencer state
  logic       rd_q, rd_d;          // current transfer is a read
  logic [7:0] adr_q, adr_d;        // latched address
  logic [7:0] dat_q, dat_d;        // write data / read capture
  logic [2:0] cnt_q, cnt_d;        // phase timer
  logic       done_q, done_d;      // one-cycle completion pulse
  logic [7:0] bus_s1_q, bus_s2_q;  // bus synchroniser

  // next state: address phase, latch, strobe phase, release
  always_comb
  begin
    st_d   = st_q;
    rd_d   = rd_q;
    adr_d  = adr_q;
    dat_d  = dat_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    case (st_q)
      UHP_H_IDLE:
      begin
        if (i_wr || i_rd)
        begin
          rd_d  = i_rd;
          adr_d = i_addr;
          dat_d = i_wdata;
          cnt_d = 3'(`UHP_T_SETUP);
          st_d  = UHP_H_ADDR;
        end
      end
      UHP_H_ADDR:                           // address shown
      begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1)
        begin
          cnt_d = 3'(`UHP_T_SETUP);
          st_d  = UHP_H_ALAT;
        end
      end
      UHP_H_ALAT:                           // latch high, data phase
      begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1)
        begin
          // a read waits for the device's synced answer to come back
          if (rd_q)
            cnt_d = 3'(`UHP_T_RDSTRB);
          else
            cnt_d = 3'(`UHP_T_HOLD) + 3'h1;
          st_d  = UHP_H_STRB;
        end
      end
      UHP_H_STRB:                           // strobe low
      begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1)
        begin
          if (rd_q)
            dat_d = bus_s2_q;               // capture before rise
          st_d = UHP_H_DONE;
        end
      end
      UHP_H_DONE:
      begin
        done_d = 1'b1;
        st_d   = UHP_H_GAP;
      end
      UHP_H_GAP:
        st_d = UHP_H_IDLE;
      default:
        st_d = UHP_H_IDLE;
    endcase
  end

  // register the sequencer
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st_q     <= UHP_H_IDLE;
      rd_q     <= 1'b0;
      adr_q    <= 8'h00;
      dat_q    <= 8'h00;
      cnt_q    <= 3'h0;
      done_q   <= 1'b0;
      bus_s1_q <= 8'h00;
      bus_s2_q <= 8'h00;
    end
    else
    begin
      st_q     <= st_d;
      rd_q     <= rd_d;
      adr_q    <= adr_d;
      dat_q    <= dat_d;
      cnt_q    <= cnt_d;
      done_q   <= done_d;
      bus_s1_q <= bus.shared_bus;
      bus_s2_q <= bus_s1_q;
    end
  end

  // pin drive: chip select spans the whole transfer and one cycle
  // past the strobe rise, so the device sees it selected at the edge
  always_comb
  begin
    bus.cs_n         = !(st_q inside {UHP_H_ADDR, UHP_H_ALAT,
                                      UHP_H_STRB, UHP_H_DONE});
    bus.addr_latch_n = !(st_q == UHP_H_ADDR);
    bus.rd_strobe_n  = !(st_q == UHP_H_STRB && rd_q);
    bus.wr_strobe_n  = !(st_q == UHP_H_STRB && !rd_q);
    bus.host_bus_o   = (st_q == UHP_H_ADDR) ? adr_q : dat_q;
    bus.host_bus_oe  = (st_q == UHP_H_ADDR) ||
                       (!rd_q && st_q inside {UHP_H_ALAT, UHP_H_STRB,
                                              UHP_H_DONE}); // hold
  end

  assign o_rdata = dat_q;
  assign o_done  = done_q;
  assign o_busy  = (st_q != UHP_H_IDLE);
endmodule : uhp_host

// ==== rtl/uhp_dev.sv ====
// The register addresses and the strobed register port were chosen for this implementation.
`include "uhp_cfg.svh"
module uhp_dev
(
  // clock and resets
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_master_rst_n,
  input  wire logic        i_sleep_req,
  // serial and modem pins
  input  wire logic        i_rx,
  input  wire logic        i_ring_ind_n,
  output logic             o_tx,
  output logic             o_rts_n,
  output logic             o_dtr_n,
  // internal serial core side
  input  wire logic        i_core_tx,
  input  wire logic        i_core_tx_en,
  output logic             o_core_rx,
  output logic             o_osc_run,
  // host pins
  uhp_if.dev               bus
);
  import uhp_pkg::*;

  // synchronisers for every pin from the outside
  logic [7:0] bus_s1_q;            // shared bus, first stage
  logic [7:0] bus_s2_q;            // shared bus, second stage
  logic [4:0] ctl_s1_q;            // cs, latch, rd, wr, ring
  logic [4:0] ctl_s2_q;            // same, second stage
  logic [2:0] mis_s1_q;            // rx, master reset, sleep
  logic [2:0] mis_s2_q;            // same, second stage
  logic       rd_p_q;              // previous synced read strobe
  logic       wr_p_q;              // previous synced write strobe
  logic       slp_p_q;             // previous synced sleep
  logic       ring_p_q;            // previous synced ring
  // registers
  logic [7:0] mctl_q, mctl_d;      // modem_ctrl_reg
  logic [7:0] ier_q, ier_d;        // interrupt enable
  logic [7:0] spr_q, spr_d;        // scratch
  logic [7:0] adr_q, adr_d;        // address latch
  logic       ring_ev_q, ring_ev_d; // sticky ring event
  logic [7:0] rdo_q, rdo_d;        // driven read byte
  logic       rdoe_q, rdoe_d;      // read byte drive enable
  logic       tx_q, tx_d;          // transmit pin
  logic       rts_q, rts_d;        // request-to-send pin
  logic       dtr_q, dtr_d;        // terminal-ready pin
  logic       crx_q, crx_d;        // receive into core
  logic       irq_q, irq_d;        // interrupt level
  logic       irqe_q, irqe_d;      // interrupt driver enable
  logic       osc_q, osc_d;        // oscillator running
  // decoded synced pins
  logic       cs_n;
  logic       lat_n;
  logic       rd_n;
  logic       wr_n;
  logic       ring_n;
  logic       rx;
  logic       mrst_n;
  logic       slp;
  logic       wipe;                // master reset or sleep release returns defaults
  logic       sel;                 // device addressed
  logic       rd_fall;             // read start seen
  logic       wr_rise;             // write commit seen
  logic       irq_act;             // interrupt pending and enabled
  logic [2:0] idx;                 // register index

  always_comb
  begin
    {cs_n, lat_n, rd_n, wr_n, ring_n} = ctl_s2_q;
    {rx, mrst_n, slp} = mis_s2_q;
    // falling sleep edge and master reset both wipe state
    wipe    = !mrst_n || (slp_p_q && !slp);
    sel     = !cs_n && !slp && (adr_q[7:6] == 2'h0);
    rd_fall = sel && lat_n && rd_p_q && !rd_n;
    wr_rise = sel && lat_n && !wr_p_q && wr_n;
    idx     = adr_q[`UHP_IDX_MSB:`UHP_IDX_LSB];
  end

  // next values for registers and pins
  always_comb
  begin
    mctl_d  = mctl_q;
    ier_d   = ier_q;
    spr_d   = spr_q;
    adr_d   = adr_q;
    ring_ev_d = ring_ev_q;
    rdo_d   = rdo_q;
    rdoe_d  = rdoe_q;
    if (!cs_n && !lat_n && !slp)
      adr_d = bus_s2_q;
    if (wr_rise)
    begin
      case (idx)
        `UHP_IDX_MCTL: mctl_d = bus_s2_q;
        `UHP_IDX_IER: ier_d = bus_s2_q;
        `UHP_IDX_SPR: spr_d = bus_s2_q;
        default:      ;
      endcase
    end
    if (rd_fall)
    begin
      rdoe_d = 1'b1;
      case (idx)
        `UHP_IDX_MCTL: rdo_d = {1'b0, !ring_n, mctl_q[5:0]};
        `UHP_IDX_IER: rdo_d = ier_q;
        `UHP_IDX_MSR: rdo_d = {1'b0, !ring_n, 5'h00, ring_ev_q};
        `UHP_IDX_SPR: rdo_d = spr_q;
        default:      rdo_d = 8'h00;
      endcase
      if (idx == `UHP_IDX_MSR)
        ring_ev_d = 1'b0;                             // read clears
    end
    if (rd_n || cs_n || slp)
      rdoe_d = 1'b0;                                  // release bus
    if (!ring_p_q && ring_n)
      ring_ev_d = 1'b1;                               // set wins
    // a wipe overrides any access landing in the same cycle
    if (wipe)
    begin
      mctl_d    = `UHP_RST_BYTE;
      ier_d     = `UHP_RST_BYTE;
      spr_d     = `UHP_RST_BYTE;
      adr_d     = `UHP_RST_BYTE;
      ring_ev_d = 1'b0;
      rdoe_d    = 1'b0;
    end
    // pins
    irq_act = ring_ev_q && ier_q[`UHP_IE_MSI];
    osc_d   = !slp;
    crx_d   = mctl_q[`UHP_MC_LOOP] ? i_core_tx : rx;
    tx_d    = 1'b1;
    if (!mctl_q[`UHP_MC_LOOP] && i_core_tx_en && !slp)
      tx_d = i_core_tx;
    rts_d   = !(mctl_q[`UHP_MC_RTS] && !slp);
    dtr_d   = !mctl_q[`UHP_MC_DTR];
    if (mctl_q[`UHP_MC_OSRC])
    begin
      irq_d  = 1'b1;
      irqe_d = irq_act;
    end
    else
    begin
      irq_d  = irq_act;
      irqe_d = 1'b1;
    end
    if (wipe)
    begin
      tx_d   = 1'b1;
      rts_d  = 1'b1;
      dtr_d  = 1'b1;
      crx_d  = 1'b1;
      irq_d  = 1'b0;
      irqe_d = 1'b1;
    end
  end

  // register everything; the first sync stage feeds only the second
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      // control and misc sync stages start at idle pin levels so no false edge follows; bus stages start at 00
      bus_s1_q  <= 8'h00;
      bus_s2_q  <= 8'h00;
      ctl_s1_q  <= 5'h1F;
      ctl_s2_q  <= 5'h1F;
      mis_s1_q  <= 3'h6;
      mis_s2_q  <= 3'h6;
      rd_p_q    <= 1'b1;
      wr_p_q    <= 1'b1;
      slp_p_q   <= 1'b0;
      ring_p_q  <= 1'b1;
      mctl_q    <= `UHP_RST_BYTE;
      ier_q     <= `UHP_RST_BYTE;
      spr_q     <= `UHP_RST_BYTE;
      adr_q     <= `UHP_RST_BYTE;
      ring_ev_q <= 1'b0;
      rdo_q     <= 8'h00;
      rdoe_q    <= 1'b0;
      tx_q      <= 1'b1;
      rts_q     <= 1'b1;
      dtr_q     <= 1'b1;
      crx_q     <= 1'b1;
      irq_q     <= 1'b0;
      irqe_q    <= 1'b1;
      osc_q     <= 1'b1;
    end
    else
    begin
      bus_s1_q  <= bus.shared_bus;
      bus_s2_q  <= bus_s1_q;
      ctl_s1_q  <= {bus.cs_n, bus.addr_latch_n, bus.rd_strobe_n,
                    bus.wr_strobe_n, i_ring_ind_n};
      ctl_s2_q  <= ctl_s1_q;
      mis_s1_q  <= {i_rx, i_master_rst_n, i_sleep_req};
      mis_s2_q  <= mis_s1_q;
      rd_p_q    <= rd_n;
      wr_p_q    <= wr_n;
      slp_p_q   <= slp;
      ring_p_q  <= ring_n;
      mctl_q    <= mctl_d;
      ier_q     <= ier_d;
      spr_q     <= spr_d;
      adr_q     <= adr_d;
      ring_ev_q <= ring_ev_d;
      rdo_q     <= rdo_d;
      rdoe_q    <= rdoe_d;
      tx_q      <= tx_d;
      rts_q     <= rts_d;
      dtr_q     <= dtr_d;
      crx_q     <= crx_d;
      irq_q     <= irq_d;
      irqe_q    <= irqe_d;
      osc_q     <= osc_d;
    end
  end

  assign bus.dev_bus_o  = rdo_q;
  assign bus.dev_bus_oe = rdoe_q;
  assign bus.irq_o      = irq_q;
  assign bus.irq_oe     = irqe_q;
  assign o_tx      = tx_q;
  assign o_rts_n   = rts_q;
  assign o_dtr_n   = dtr_q;
  assign o_core_rx = crx_q;
  assign o_osc_run = osc_q;
endmodule : uhp_dev

// ==== verification/uhp_properties.sv ====
module uhp_properties
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  // interface lines
  input  wire logic [7:0] host_bus_o,
  input  wire logic       host_bus_oe,
  input  wire logic       dev_bus_oe,
  input  wire logic [7:0] shared_bus,
  input  wire logic       cs_n,
  input  wire logic       addr_latch_n,
  input  wire logic       rd_strobe_n,
  input  wire logic       wr_strobe_n,
  input  wire logic       irq_o,
  input  wire logic       irq_oe
);
  logic [7:0] addr_q;  // last latched address
  logic [7:0] addr_d;
  // follow the address phase so selection can be judged later
  always_comb
  begin
    addr_d = (!cs_n && !addr_latch_n) ? shared_bus : addr_q;
  end
  always_ff @(posedge i_mclk)
  begin
    addr_q <= i_srst ? 8'h00 : addr_d;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_no_clash: assert property (
    !(host_bus_oe && dev_bus_oe)) else $error("both ends drive bus");
  a_rd_answer: assert property (
    ($fell(rd_strobe_n) && addr_q[7:6] == 2'h0) |-> ##[1:4] dev_bus_oe)
    else $error("read not answered");
  a_rd_release: assert property (
    $rose(rd_strobe_n) |-> ##[1:5] !dev_bus_oe)
    else $error("bus not released");
  a_unsel_quiet: assert property (
    (addr_q[7:6] != 2'h0 && !rd_strobe_n) |-> !dev_bus_oe)
    else $error("unselected device drove bus");
  a_strobe_phase: assert property (
    (!rd_strobe_n || !wr_strobe_n) |-> addr_latch_n && !cs_n)
    else $error("strobe outside data phase");
  a_latch_cs: assert property (
    !addr_latch_n |-> !cs_n && host_bus_oe) else $error("bad address phase");
  a_wr_hold: assert property (
    !wr_strobe_n |-> host_bus_oe && $stable(host_bus_o))
    else $error("write data moved");
  a_wr_width: assert property (
    $fell(wr_strobe_n) |-> !wr_strobe_n [*3] ##1 wr_strobe_n)
    else $error("write strobe width");
  a_irq_drive: assert property (
    irq_o || irq_oe) else $error("interrupt pin mode");
  a_reset_idle: assert property (@(posedge i_mclk) disable iff (1'b0)
    i_srst |=> cs_n && !dev_bus_oe) else $error("reset not idle");
  // main scenarios reached
  c_write: cover property ($rose(wr_strobe_n));
  c_read: cover property ($fell(dev_bus_oe));
  c_open_src: cover property (!irq_oe);
endmodule : uhp_properties

// ==== verification/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // one row: op, address, data or expected read, {rts_n,dtr_n}
  typedef struct packed
  {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [1:0] pins;
  } uhp_row_t;
  localparam uhp_row_t ROWS [9] = '{
    '{1'b1, 8'h0E, 8'hA5, 2'h3},
    '{1'b0, 8'h0E, 8'hA5, 2'h3},
    '{1'b1, 8'h4E, 8'h11, 2'h3},  // select bit 6 set: ignored
    '{1'b1, 8'h8E, 8'h22, 2'h3},  // select bit 7 set: ignored
    '{1'b0, 8'h0E, 8'hA5, 2'h3},
    '{1'b0, 8'h4E, 8'hFF, 2'h3},  // nobody answers, lines float
    '{1'b1, 8'h08, 8'h02, 2'h1},
    '{1'b1, 8'h08, 8'h01, 2'h2},
    '{1'b1, 8'h08, 8'h00, 2'h3}};
  logic       i_mclk;
  logic       i_srst;
  logic       cmd_wr;
  logic       cmd_rd;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic [7:0] rdata;
  logic       done;
  logic       busy;
  logic       mrst_n;
  logic       sleep;
  logic       rx;
  logic       ring_n;
  logic       core_tx;
  logic       core_tx_en;
  logic       tx;
  logic       rts_n;
  logic       dtr_n;
  logic       core_rx;
  logic       osc_run;
  int         n_fail;
  int         check_count;
  uhp_if bus_if();
  uhp_host u_uhp_host (.i_mclk(i_mclk), .i_srst(i_srst), .i_wr(cmd_wr),
    .i_rd(cmd_rd), .i_addr(cmd_addr), .i_wdata(cmd_wdata), .o_rdata(rdata),
    .o_done(done), .o_busy(busy), .bus(bus_if.host));
  uhp_dev u_uhp_dev (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_master_rst_n(mrst_n), .i_sleep_req(sleep), .i_rx(rx),
    .i_ring_ind_n(ring_n), .o_tx(tx), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
    .i_core_tx(core_tx), .i_core_tx_en(core_tx_en), .o_core_rx(core_rx),
    .o_osc_run(osc_run), .bus(bus_if.dev));
  uhp_properties u_uhp_properties (.i_mclk(i_mclk), .i_srst(i_srst),
    .host_bus_o(bus_if.host_bus_o), .host_bus_oe(bus_if.host_bus_oe),
    .dev_bus_oe(bus_if.dev_bus_oe), .shared_bus(bus_if.shared_bus),
    .cs_n(bus_if.cs_n), .addr_latch_n(bus_if.addr_latch_n),
    .rd_strobe_n(bus_if.rd_strobe_n), .wr_strobe_n(bus_if.wr_strobe_n),
    .irq_o(bus_if.irq_o), .irq_oe(bus_if.irq_oe));
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // pins pass two sync stages and a register, so give them time
  task automatic settle;
    repeat (5) @(negedge i_mclk);
  endtask : settle
  // one host transfer; a hung sequencer ends the run
  task automatic do_op(input logic w, input logic [7:0] a, d);
    int k;
    @(posedge i_mclk);
    cmd_wr <= w;
    cmd_rd <= !w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge i_mclk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++)
      @(negedge i_mclk);
    if (k == 20)
    begin
      n_fail++;
      print_verdict();
    end
    else
      @(posedge i_mclk);
  endtask : do_op
  initial
  begin
    {i_srst, mrst_n, rx, ring_n, core_tx} = 5'h1F;
    {cmd_wr, cmd_rd, sleep, core_tx_en} = 4'h0;
    {cmd_addr, cmd_wdata} = 16'h0000;
    n_fail = 0;
    check_count = 0;
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(negedge i_mclk);
    chk("idle pins", {tx, rts_n, dtr_n, bus_if.irq_oe}, 8'h0F);
    chk("irq", bus_if.irq_o, 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      do_op(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w)
        chk("rdata", rdata, ROWS[i].d);
      settle();
      chk("modem pins", {rts_n, dtr_n}, ROWS[i].pins);
      chk("busy", busy, 8'h00);
    end
    // tx follows core data; then loopback turns the pin off
    @(posedge i_mclk);
    core_tx_en <= 1'b1;
    core_tx <= 1'b0;
    settle();
    chk("tx", tx, 8'h00);
    do_op(1'b1, 8'h08, 8'h10);
    settle();
    chk("tx loop", {tx, core_rx}, 8'h02);
    @(posedge i_mclk);
    core_tx <= 1'b1;
    rx <= 1'b0;
    settle();
    chk("core_rx", core_rx, 8'h01);
    do_op(1'b1, 8'h08, 8'h00);
    core_tx_en <= 1'b0;
    core_tx <= 1'b0;
    settle();
    chk("tx off", {tx, core_rx}, 8'h02);
    @(posedge i_mclk);
    rx <= 1'b1;
    // ring rise in open-source, then push-pull, then clear by read
    do_op(1'b1, 8'h08, 8'h08);
    settle();
    chk("irq os", {bus_if.irq_o, bus_if.irq_oe}, 8'h02);
    do_op(1'b1, 8'h02, 8'h08);
    ring_n <= 1'b0;
    settle();
    @(posedge i_mclk);
    ring_n <= 1'b1;
    settle();
    chk("irq oe", bus_if.irq_oe, 8'h01);
    do_op(1'b1, 8'h08, 8'h00);
    settle();
    chk("irq pp", {bus_if.irq_o, bus_if.irq_oe}, 8'h03);
    do_op(1'b0, 8'h0C, 8'h00);
    chk("ring event", rdata & 8'h01, 8'h01);
    settle();
    chk("irq clr", bus_if.irq_o, 8'h00);
    // master reset with tx data pending and modem pins on
    do_op(1'b1, 8'h0E, 8'h77);
    do_op(1'b1, 8'h08, 8'h03);
    core_tx_en <= 1'b1;
    mrst_n <= 1'b0;
    settle();
    chk("mrst pins", {tx, rts_n, dtr_n}, 8'h07);
    @(posedge i_mclk);
    mrst_n <= 1'b1;
    settle();
    do_op(1'b0, 8'h0E, 8'h00);
    chk("mrst scratch", rdata, 8'h00);
    // sleep: clock stops, tx and rts idle, writes lost, release resets
    do_op(1'b1, 8'h0E, 8'h33);
    do_op(1'b1, 8'h08, 8'h02);
    sleep <= 1'b1;
    settle();
    chk("sleep pins", {osc_run, tx, rts_n}, 8'h03);
    do_op(1'b1, 8'h0E, 8'h44);
    sleep <= 1'b0;
    settle();
    chk("osc", osc_run, 8'h01);
    do_op(1'b0, 8'h0E, 8'h00);
    chk("wake scratch", rdata, 8'h00);
    print_verdict();
  end
endmodule : tb
